// *** hdl/dim_pkg.sv ***
// Package of the diagnostic I/O monitor: register map, field positions,
// reset values, screen and sequence states, and display carrier.
// Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock.
package dim_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FORCE = 8'h04;
  localparam logic [7:0] REG_IOASN = 8'h08;
  localparam logic [7:0] REG_OFFSET = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IOSTATE = 8'h14;

  // ==========================================================
  // Field positions and widths
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_POS_BIT = 1;
  localparam int CTRL_INERTIA_BIT = 2;
  localparam int IOASN_SON_LSB = 0;
  localparam int IOASN_RDY_LSB = 4;
  localparam int IOST_DO_LSB = 16;
  localparam int STAT_SCR_LSB = 5;
  localparam int DI_N = 12;
  localparam int DO_N = 7;
  localparam int TOP_N = 10;
  localparam int BOT_N = 9;

  // ==========================================================
  // Reset values
  localparam logic [3:0] SON_LINE_RST = 4'h0;
  localparam logic [2:0] RDY_LINE_RST = 3'h0;
  localparam logic [DO_N-1:0] FORCE_VAL_RST = 7'h00;

  // ==========================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // States
  typedef enum logic [2:0] {
    SCR_INIT,
    SCR_STATUS,
    SCR_IO,
    SCR_FORCE,
    SCR_JOG,
    SCR_OFFSET
  } dim_screen_t;

  typedef enum logic [1:0] {
    OFS_IDLE,
    OFS_EDIT,
    OFS_RUN
  } dim_ofs_t;

  // Seven-segment line picture: top row inputs one to ten, bottom row inputs eleven and twelve, then outputs.
  typedef struct packed {
    logic [TOP_N-1:0] top;
    logic [BOT_N-1:0] bot;
  } dim_disp_t;

endpackage : dim_pkg

// *** hdl/dim_offset_avg.sv ***
// Offset averager: sums a power-of-two number of signed samples and
// returns their mean. Assumes samples arrive with a valid strobe.
module dim_offset_avg #(
  parameter int W = 16,
  parameter int LOG2N = 4
) (
  input wire logic mclk_i, // clock
  input wire logic rst_i, // asynchronous reset, active high
  input wire logic start_i, // begin a measurement
  input wire logic valid_i, // sample strobe
  input wire logic signed [W-1:0] sample_i, // sample
  output logic busy_o, // measuring
  output logic done_o, // result pulse
  output logic signed [W-1:0] avg_o // registered mean
);

  logic signed [W+LOG2N-1:0] sum_r;
  logic [LOG2N:0] cnt_r;
  logic signed [W+LOG2N-1:0] sum_nxt;

  assign sum_nxt = sum_r + (W+LOG2N)'(sample_i);

  // ==========================================================
  // Accumulation
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sum_r <= '0;
      cnt_r <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      avg_o <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i && !busy_o)
      begin
        sum_r <= '0;
        cnt_r <= '0;
        busy_o <= 1'b1;
      end
      else if (busy_o && valid_i)
      begin
        sum_r <= sum_nxt;
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == (LOG2N+1)'((1 << LOG2N) - 1))
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          avg_o <= W'(sum_nxt >>> LOG2N);
        end
      end
    end
  end

endmodule : dim_offset_avg

// *** hdl/dim_monitor.sv ***
// Diagnostic I/O monitor of a drive front panel: status indication,
// line display, forced outputs, offset zeroing and test-mode gating.
// Assumes synchronous key levels and an AXI4-Lite master on the bus.
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.

module dim_monitor #(
  parameter int ADC_W = 16,
  parameter int AVG_LOG2N = 4
) (
  input wire logic mclk_i, // 50 MHz clock
  input wire logic rst_i, // asynchronous reset, active high
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic init_done_i, // drive initialisation finished
  input wire logic alarm_i, // any alarm active
  input wire logic ext_cmd_i, // external command present
  input wire logic [dim_pkg::DI_N-1:0] di_i, // input lines one to twelve
  input wire logic [dim_pkg::DO_N-1:0] do_norm_i, // computed outputs, extra line on top
  input wire logic key_mode_i, // mode key held
  input wire logic key_set_i, // set key held
  input wire logic key_up_i, // up key held
  input wire logic key_down_i, // down key held
  input wire logic signed [ADC_W-1:0] adc_i, // analog command sample
  input wire logic adc_valid_i, // sample strobe
  output logic ready_ind_o, // ready indication
  output logic not_ready_ind_o, // not_ready_indication
  output dim_pkg::dim_disp_t disp_o, // segment picture
  output logic [dim_pkg::DO_N-1:0] do_o, // output line drive
  output dim_pkg::dim_screen_t screen_o, // current screen
  output logic jog_ccw_o, // JOG counter-clockwise run
  output logic jog_cw_o, // JOG clockwise run
  output logic pos_test_o, // positioning test running
  output logic inertia_o, // inertia estimation running
  output logic signed [ADC_W-1:0] cmd_o, // offset-corrected command
  output logic signed [ADC_W-1:0] analog_offset_parameter_o // stored offset
);

  // ==========================================================
  // Declarations
  function automatic logic line_bit(input logic [15:0] lines, input logic [3:0] idx);
    line_bit = lines[idx];
  endfunction : line_bit

  dim_pkg::dim_screen_t scr_r;
  dim_pkg::dim_ofs_t ofs_r;
  logic [3:0] key_q_r;
  logic [3:0] press;
  logic ctrl_force_r, ctrl_pos_r, ctrl_inert_r;
  logic [dim_pkg::DO_N-1:0] force_val_r;
  logic [2:0] force_sel_r;
  logic [3:0] son_line_r;
  logic [2:0] rdy_line_r;
  logic force_act_r, pos_act_r, inert_act_r;
  logic ofs_pick_r;
  logic test_ok, servo_on, ready;
  logic [dim_pkg::DO_N-1:0] do_base;
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstb_r;
  logic wr_en;
  logic avg_start, avg_busy, avg_done;
  logic signed [ADC_W-1:0] avg_val;

  assign press = {key_mode_i, key_set_i, key_up_i, key_down_i} & ~key_q_r;
  assign test_ok = !ext_cmd_i && !alarm_i;
  assign servo_on = line_bit(16'(di_i), son_line_r);
  assign ready = init_done_i && !alarm_i && servo_on;

  always_comb
  begin
    do_base = do_norm_i;
    do_base[rdy_line_r] = ready;
  end

  // ==========================================================
  // AXI4-Lite slave
  assign s_axi_awready = !aw_got_r;
  assign s_axi_wready = !w_got_r;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_en = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstb_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dim_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstb_r <= s_axi_wstrb[0];
      end
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r <= dim_pkg::REG_OFFSET && awaddr_r[1:0] == 2'h0) ?
                       dim_pkg::RESP_OKAY : dim_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= dim_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= dim_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
      unique case (s_axi_araddr)
        dim_pkg::REG_CTRL: s_axi_rdata <= 32'({ctrl_inert_r, ctrl_pos_r, ctrl_force_r});
        dim_pkg::REG_FORCE: s_axi_rdata <= 32'(force_val_r);
        dim_pkg::REG_IOASN: s_axi_rdata <= 32'({1'b0, rdy_line_r, son_line_r});
        dim_pkg::REG_OFFSET: s_axi_rdata <= 32'($unsigned(analog_offset_parameter_o));
        dim_pkg::REG_STATUS: s_axi_rdata <= 32'({scr_r, avg_busy, inert_act_r, pos_act_r,
                                                  force_act_r, ready_ind_o});
        dim_pkg::REG_IOSTATE: s_axi_rdata <= (32'(do_o) << dim_pkg::IOST_DO_LSB) | 32'(di_i);
        default: s_axi_rresp <= dim_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers written by software and panel keys
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_force_r <= 1'b0;
      ctrl_pos_r <= 1'b0;
      ctrl_inert_r <= 1'b0;
      force_val_r <= dim_pkg::FORCE_VAL_RST;
      force_sel_r <= '0;
      son_line_r <= dim_pkg::SON_LINE_RST;
      rdy_line_r <= dim_pkg::RDY_LINE_RST;
      key_q_r <= '0;
    end
    else
    begin
      key_q_r <= {key_mode_i, key_set_i, key_up_i, key_down_i};
      if (wr_en && awaddr_r == dim_pkg::REG_CTRL && wstb_r)
      begin
        ctrl_force_r <= wdata_r[dim_pkg::CTRL_FORCE_BIT];
        ctrl_pos_r <= wdata_r[dim_pkg::CTRL_POS_BIT];
        ctrl_inert_r <= wdata_r[dim_pkg::CTRL_INERTIA_BIT];
      end
      else if (scr_r == dim_pkg::SCR_FORCE && press[2])
      begin
        ctrl_force_r <= !ctrl_force_r;
      end
      if (wr_en && awaddr_r == dim_pkg::REG_FORCE && wstb_r)
      begin
        force_val_r <= wdata_r[dim_pkg::DO_N-1:0];
      end
      else if (scr_r == dim_pkg::SCR_FORCE && force_act_r && press[0])
      begin
        force_val_r[force_sel_r] <= !force_val_r[force_sel_r];
      end
      if (scr_r == dim_pkg::SCR_FORCE && press[1])
      begin
        force_sel_r <= (force_sel_r == 3'(dim_pkg::DO_N - 1)) ? 3'h0 : force_sel_r + 3'h1;
      end
      if (wr_en && awaddr_r == dim_pkg::REG_IOASN && wstb_r)
      begin
        son_line_r <= wdata_r[dim_pkg::IOASN_SON_LSB +: 4];
        rdy_line_r <= wdata_r[dim_pkg::IOASN_RDY_LSB +: 3];
      end
    end
  end

  // ==========================================================
  // Screen selection
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scr_r <= dim_pkg::SCR_INIT;
    end
    else if (press[3])
    begin
      unique case (scr_r)
        dim_pkg::SCR_INIT: scr_r <= dim_pkg::SCR_STATUS;
        dim_pkg::SCR_STATUS: scr_r <= dim_pkg::SCR_IO;
        dim_pkg::SCR_IO: scr_r <= dim_pkg::SCR_FORCE;
        dim_pkg::SCR_FORCE: scr_r <= dim_pkg::SCR_JOG;
        dim_pkg::SCR_JOG: scr_r <= dim_pkg::SCR_OFFSET;
        dim_pkg::SCR_OFFSET: scr_r <= dim_pkg::SCR_STATUS;
        default: scr_r <= dim_pkg::SCR_STATUS;
      endcase
    end
  end

  assign screen_o = scr_r;

  // ==========================================================
  // Test modes: forced outputs and host-link tests
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      force_act_r <= 1'b0;
      pos_act_r <= 1'b0;
      inert_act_r <= 1'b0;
    end
    else
    begin
      force_act_r <= ctrl_force_r && (force_act_r || test_ok);
      pos_act_r <= ctrl_pos_r && (pos_act_r ? !alarm_i : test_ok);
      inert_act_r <= ctrl_inert_r && (inert_act_r ? !alarm_i : test_ok);
    end
  end

  // ==========================================================
  // Registered outputs: indication, display, lines, JOG
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ready_ind_o <= 1'b0;
      not_ready_ind_o <= 1'b1;
      disp_o <= '0;
      do_o <= '0;
      jog_ccw_o <= 1'b0;
      jog_cw_o <= 1'b0;
    end
    else
    begin
      ready_ind_o <= ready;
      not_ready_ind_o <= !ready;
      do_o <= force_act_r ? force_val_r : do_base;
      disp_o.top <= di_i[dim_pkg::TOP_N-1:0];
      disp_o.bot <= {di_i[dim_pkg::DI_N-1:dim_pkg::TOP_N], do_o};
      jog_ccw_o <= scr_r == dim_pkg::SCR_JOG && test_ok && key_up_i;
      jog_cw_o <= scr_r == dim_pkg::SCR_JOG && test_ok && key_down_i && !key_up_i;
    end
  end

  assign pos_test_o = pos_act_r;
  assign inertia_o = inert_act_r;

  // ==========================================================
  // Automatic offset sequence
  assign avg_start = ofs_r == dim_pkg::OFS_EDIT && press[2] && ofs_pick_r;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ofs_r <= dim_pkg::OFS_IDLE;
      ofs_pick_r <= 1'b0;
    end
    else
    begin
      unique case (ofs_r)
        dim_pkg::OFS_IDLE:
          if (scr_r == dim_pkg::SCR_OFFSET && press[2])
          begin
            ofs_r <= dim_pkg::OFS_EDIT;
            ofs_pick_r <= 1'b0;
          end
        dim_pkg::OFS_EDIT:
          if (scr_r != dim_pkg::SCR_OFFSET)
          begin
            ofs_r <= dim_pkg::OFS_IDLE;
          end
          else if (press[2])
          begin
            ofs_r <= ofs_pick_r ? dim_pkg::OFS_RUN : dim_pkg::OFS_IDLE;
          end
          else if (press[1] || press[0])
          begin
            ofs_pick_r <= !ofs_pick_r;
          end
        dim_pkg::OFS_RUN:
          if (avg_done)
          begin
            ofs_r <= dim_pkg::OFS_IDLE;
          end
        default: ofs_r <= dim_pkg::OFS_IDLE;
      endcase
    end
  end

  dim_offset_avg #(
    .W(ADC_W),
    .LOG2N(AVG_LOG2N)
  ) u_avg (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(avg_start),
    .valid_i(adc_valid_i),
    .sample_i(adc_i),
    .busy_o(avg_busy),
    .done_o(avg_done),
    .avg_o(avg_val)
  );

  // The measured result wins over a software write in the same cycle.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      analog_offset_parameter_o <= '0;
      cmd_o <= '0;
    end
    else
    begin
      if (avg_done)
      begin
        analog_offset_parameter_o <= avg_val;
      end
      else if (wr_en && awaddr_r == dim_pkg::REG_OFFSET && wstb_r)
      begin
        analog_offset_parameter_o <= wdata_r[ADC_W-1:0];
      end
      cmd_o <= adc_i - analog_offset_parameter_o;
    end
  end

  // ==========================================================
  // Checks
  chk_not_ready_ind: assert property (@(posedge mclk_i) disable iff (rst_i)
    (alarm_i || !init_done_i || !servo_on) |=> (not_ready_ind_o && !ready_ind_o))
    else $error("not ready indication missing");
  chk_ready_ind: assert property (@(posedge mclk_i) disable iff (rst_i)
    ready |=> ready_ind_o)
    else $error("ready indication missing");
  chk_top_row: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> disp_o.top == $past(di_i[dim_pkg::TOP_N-1:0]))
    else $error("top row does not follow inputs");
  chk_bottom_inputs: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> disp_o.bot[dim_pkg::BOT_N-1 -: 2] == $past(di_i[dim_pkg::DI_N-1 -: 2]))
    else $error("bottom row lacks inputs eleven and twelve");
  chk_force_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!force_act_r && !test_ok) |=> !force_act_r)
    else $error("forced mode entered under command or alarm");
  chk_force_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
    force_act_r |=> do_o == $past(force_val_r))
    else $error("forced value not driven");
  chk_force_exit: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(force_act_r) |=> do_o == $past(do_base))
    else $error("outputs not restored after forcing");
  chk_offset_store: assert property (@(posedge mclk_i) disable iff (rst_i)
    avg_done |=> analog_offset_parameter_o == $past(avg_val))
    else $error("measured offset not stored");
  chk_jog_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
    !test_ok |=> !jog_ccw_o && !jog_cw_o)
    else $error("JOG ran under command or alarm");
  chk_host_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!pos_act_r && !test_ok) |=> !pos_test_o)
    else $error("positioning started under command or alarm");
  chk_mode_key: assert property (@(posedge mclk_i) disable iff (rst_i)
    (scr_r == dim_pkg::SCR_INIT && press[3]) |=> scr_r == dim_pkg::SCR_STATUS)
    else $error("mode key did not open diagnostics");

endmodule : dim_monitor

// *** testbench/dim_panel_model.sv ***
// Keypad partner of the diagnostic monitor: presses and holds panel keys.
// Assumes the bench clock; keys change only just after a rising edge.
module dim_panel_model (
  input wire logic mclk_i, // clock
  output logic key_mode_o, // mode key
  output logic key_set_o, // set key
  output logic key_up_o, // up key
  output logic key_down_o // down key
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] keys = 4'h0;

  assign {key_down_o, key_up_o, key_set_o, key_mode_o} = keys;

  // ==========================================================
  // Key actions
  // Index 0 mode, 1 set, 2 up, 3 down; a press is one cycle and a gap.
  task automatic press(input int k);
    @(posedge mclk_i);
    keys[k] <= 1'b1;
    @(posedge mclk_i);
    keys <= 4'h0;
    @(posedge mclk_i);
  endtask : press

  task automatic hold(input logic [3:0] v);
    @(posedge mclk_i);
    keys <= v;
  endtask : hold

  // Set, choose 1 with up, set again.
  task automatic start_offset();
    press(1);
    press(2);
    press(1);
  endtask : start_offset

endmodule : dim_panel_model

// *** testbench/tb.sv ***
// Self-checking bench of the diagnostic I/O monitor.
// Assumes the keypad partner model and an AXI4-Lite master made here.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic init_done = 1'b0;
  logic alarm = 1'b0;
  logic ext_cmd = 1'b0;
  logic adc_valid = 1'b0;
  logic [11:0] di = 12'h000;
  logic [6:0] do_norm = 7'h00;
  logic [6:0] do_o, fv;
  logic wst0 = 1'b1;
  logic rdy_exp;
  logic signed [15:0] adc = 16'sh0000;
  logic signed [15:0] cmd, ofs, ov;
  logic rdy, nrdy, jccw, jcw, pos, inr, km, ks, ku, kd;
  dim_pkg::dim_disp_t disp;
  dim_pkg::dim_screen_t screen;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 32'hd86ee417;
  logic [1:0] bq[$];
  logic [33:0] rq[$];

  always #10 mclk_i = ~mclk_i;

  dim_monitor #(.ADC_W(16), .AVG_LOG2N(4)) u_dim_monitor (
    .mclk_i(mclk_i), .rst_i(rst_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .init_done_i(init_done), .alarm_i(alarm),
    .ext_cmd_i(ext_cmd), .di_i(di), .do_norm_i(do_norm),
    .key_mode_i(km), .key_set_i(ks), .key_up_i(ku), .key_down_i(kd),
    .adc_i(adc), .adc_valid_i(adc_valid), .ready_ind_o(rdy),
    .not_ready_ind_o(nrdy), .disp_o(disp), .do_o(do_o), .screen_o(screen),
    .jog_ccw_o(jccw), .jog_cw_o(jcw), .pos_test_o(pos), .inertia_o(inr),
    .cmd_o(cmd), .analog_offset_parameter_o(ofs)
  );

  dim_panel_model u_dim_panel_model (
    .mclk_i(mclk_i), .key_mode_o(km), .key_set_o(ks), .key_up_o(ku), .key_down_o(kd)
  );

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick

  // ==========================================================
  // Bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= {3'($random(seed)), wst0};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($random(seed));
    do
    begin
      @(posedge mclk_i);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (!s_axi_bready)
        s_axi_bready <= 1'b1;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($random(seed));
    do
    begin
      @(posedge mclk_i);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (!s_axi_rready)
        s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask : rd

  // Answers are compared with the oldest expectation noted by the master.
  always @(posedge mclk_i)
  begin
    if (s_axi_bvalid && s_axi_bready)
      check(s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    tick(12);
    check(nrdy, 1'b1);
    rst_i <= 1'b0;
    rd(dim_pkg::REG_CTRL, 32'h0, dim_pkg::RESP_OKAY);
    rd(dim_pkg::REG_IOASN, 32'h0, dim_pkg::RESP_OKAY);
    rd(8'h18, 32'h0, dim_pkg::RESP_SLVERR);
    wr(dim_pkg::REG_STATUS, 32'h1, dim_pkg::RESP_SLVERR);
    wr(dim_pkg::REG_IOASN, 32'h3, dim_pkg::RESP_OKAY);
    di <= 12'h008;
    init_done <= 1'b1;
    tick(3);
    check({rdy, nrdy}, 2'b10);
    alarm <= 1'b1;
    tick(2);
    check({rdy, nrdy}, 2'b01);
    alarm <= 1'b0;
    di <= 12'h001;
    tick(2);
    check({rdy, nrdy}, 2'b01);
    repeat (4)
    begin
      di <= 12'($random(seed));
      do_norm <= 7'($random(seed));
      {init_done, alarm, ext_cmd} <= 3'($random(seed));
      tick(3);
      rdy_exp = init_done && !alarm && di[3];
      check(disp.top, di[9:0]);
      check(disp.bot, {di[11:10], do_norm[6:1], rdy_exp});
      check({rdy, nrdy}, {rdy_exp, !rdy_exp});
    end
    rd(dim_pkg::REG_IOSTATE, {9'h0, do_norm[6:1], rdy_exp, 4'h0, di}, dim_pkg::RESP_OKAY);
    init_done <= 1'b1;
    alarm <= 1'b0;
    // Servo-on contact open before forcing.
    di <= 12'h000;
    fv = 7'($random(seed));
    wr(dim_pkg::REG_FORCE, {25'h0, fv}, dim_pkg::RESP_OKAY);
    ext_cmd <= 1'b1;
    wr(dim_pkg::REG_CTRL, 32'h1, dim_pkg::RESP_OKAY);
    tick(3);
    check(do_o, {do_norm[6:1], 1'b0});
    wr(dim_pkg::REG_CTRL, 32'h0, dim_pkg::RESP_OKAY);
    ext_cmd <= 1'b0;
    wr(dim_pkg::REG_CTRL, 32'h1, dim_pkg::RESP_OKAY);
    do_norm <= ~do_norm;
    tick(3);
    check(do_o, fv);
    check(disp.bot[6:0], fv);
    wr(dim_pkg::REG_CTRL, 32'h0, dim_pkg::RESP_OKAY);
    tick(3);
    check(do_o, {do_norm[6:1], 1'b0});
    ext_cmd <= 1'b1;
    wr(dim_pkg::REG_CTRL, 32'h6, dim_pkg::RESP_OKAY);
    tick(3);
    check({pos, inr}, 2'b00);
    wr(dim_pkg::REG_CTRL, 32'h0, dim_pkg::RESP_OKAY);
    ext_cmd <= 1'b0;
    wr(dim_pkg::REG_CTRL, 32'h6, dim_pkg::RESP_OKAY);
    tick(3);
    check({pos, inr}, 2'b11);
    rd(dim_pkg::REG_STATUS, 32'h0000000c, dim_pkg::RESP_OKAY);
    alarm <= 1'b1;
    tick(2);
    check({pos, inr}, 2'b00);
    alarm <= 1'b0;
    wr(dim_pkg::REG_CTRL, 32'h0, dim_pkg::RESP_OKAY);
    u_dim_panel_model.press(0);
    tick(2);
    check(screen, dim_pkg::SCR_STATUS);
    ext_cmd <= 1'b1;
    repeat (3) u_dim_panel_model.press(0);
    u_dim_panel_model.hold(4'b0100);
    tick(3);
    check({jccw, jcw}, 2'b00);
    u_dim_panel_model.hold(4'b0000);
    ext_cmd <= 1'b0;
    repeat (4) u_dim_panel_model.press(0);
    u_dim_panel_model.press(1);
    u_dim_panel_model.press(2);
    u_dim_panel_model.press(3);
    tick(2);
    check(do_o, fv ^ 7'h02);
    u_dim_panel_model.press(1);
    u_dim_panel_model.press(0);
    tick(2);
    check(do_o, {do_norm[6:1], 1'b0});
    check(screen, dim_pkg::SCR_JOG);
    u_dim_panel_model.hold(4'b0100);
    tick(3);
    check({jccw, jcw}, 2'b10);
    u_dim_panel_model.hold(4'b1000);
    tick(3);
    check({jccw, jcw}, 2'b01);
    u_dim_panel_model.hold(4'b0000);
    tick(3);
    check({jccw, jcw, pos, inr}, 4'b0000);
    u_dim_panel_model.press(0);
    check(screen, dim_pkg::SCR_OFFSET);
    ov = 16'(($random(seed) & 32'h3ff) + 1);
    adc <= ov;
    u_dim_panel_model.start_offset();
    repeat (20)
    begin
      @(posedge mclk_i);
      adc_valid <= 1'b1;
      @(posedge mclk_i);
      adc_valid <= 1'($random(seed));
    end
    tick(2);
    check(ofs, ov);
    rd(dim_pkg::REG_OFFSET, {16'h0, ov}, dim_pkg::RESP_OKAY);
    adc <= ov + 16'sh0005;
    tick(3);
    check(cmd, 16'sh0005);
    wst0 = 1'b0;
    wr(dim_pkg::REG_OFFSET, 32'h00001234, dim_pkg::RESP_OKAY);
    wst0 = 1'b1;
    rd(dim_pkg::REG_OFFSET, {16'h0, ov}, dim_pkg::RESP_OKAY);
    tick(2);
    check(ofs, ov);
    end_sim();
  end

  initial
  begin
    #100us;
    num_errors++;
    end_sim();
  end

endmodule : tb
